// ---- hdl/fws_pkg.sv ----
// Constants shared by the flash wait-state controller and its stretch counter.
// Assumes a single 40 MHz system clock and a synchronous active-low reset.
// ----------------------------------------------------------------------------
// Functional notes
// [RULE1] Each flash access lasts the access-cycle field value plus one system clocks, for field values 00 to 10.
// [RULE2] Field value 00 gives a one-clock access, fit for clocks up to 20 MHz.
// [RULE3] Field value 01 gives a two-clock access, fit for clocks up to 40 MHz.
// [RULE4] Field value 10 gives a three-clock access, fit for clocks up to 50 MHz.
// [RULE5] After reset the access-cycle field reads 10, so accesses take three clocks.
// [RULE6] Software writes back the upper thirty bits exactly as it read them.
// [RULE7] The configuration register is decoded at its fixed memory-mapped address.
// [RULE8] The reserved value 11 falls back to the safe three-clock access.
// ----------------------------------------------------------------------------
package fws_pkg;
  localparam logic [31:0] FWS_CFG_ADDR     = 32'h4003c010;
  localparam int          FWS_FIELD_LSB    = 0;
  localparam int          FWS_FIELD_W      = 2;
  localparam logic [1:0]  FWS_FIELD_RESET  = 2'h2;
  localparam logic [29:0] FWS_UPPER_RESET  = 30'h0;
  localparam logic [1:0]  FWS_FIELD_RSVD   = 2'h3;
  localparam logic [1:0]  FWS_FIELD_MAXDEF = 2'h2;
  localparam logic [31:0] FWS_UNMAPPED_RD  = 32'h0;
  localparam int          FWS_CNT_W        = 2;
endpackage : fws_pkg

// ---- hdl/fws_stretch.sv ----
// Stretch counter: holds a flash access for a programmed number of clocks.
// Assumes the requester keeps acc_req high until acc_done pulses.
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
module fws_stretch (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic                         acc_req,
  input  wire logic [fws_pkg::FWS_CNT_W-1:0] wait_cycles,
  output logic                              acc_done,
  output logic                              acc_busy
);
  typedef enum logic [0:0] {FWS_IDLE, FWS_WAIT} fws_state_t;

  fws_state_t                        state_reg,  state_next;
  logic [fws_pkg::FWS_CNT_W-1:0]     cnt_reg,    cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    acc_done   = 1'b0;
    case (state_reg)
      FWS_IDLE: begin
        if (acc_req) begin
          if (wait_cycles == '0) begin
            acc_done = 1'b1; // see [RULE2]
          end else begin
            cnt_next   = wait_cycles - 2'h1; // see [RULE1]
            state_next = FWS_WAIT;
          end
        end
      end
      FWS_WAIT: begin
        if (cnt_reg == '0) begin
          acc_done   = 1'b1;
          state_next = FWS_IDLE;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      default: state_next = FWS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= FWS_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign acc_busy = (state_reg == FWS_WAIT);

  sequence s_done_third;
    !acc_done ##1 !acc_done ##1 acc_done;
  endsequence

  chk_done_after_wait: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    (state_reg == FWS_IDLE && acc_req && wait_cycles == 2'h2) |-> s_done_third)
    else $error("three-clock access timing wrong");
endmodule : fws_stretch

// ---- hdl/fws_top.sv ----
// Flash wait-state controller: configuration register and access stretching.
// Assumes one-cycle register strobes and a flash requester holding its request.
// ----------------------------------------------------------------------------
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module fws_top (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        flash_req,
  output logic             flash_ack,
  output logic      [1:0]  access_cycle_field
);
  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  logic [1:0]  field_reg,  field_next;
  logic [29:0] upper_reg,  upper_next;
  logic [31:0] rdata_reg,  rdata_next;
  logic        ack_reg;
  logic        done;
  logic        busy;
  logic [1:0]  eff_wait;

  function automatic logic hit(input logic [31:0] a);
    hit = (a == fws_pkg::FWS_CFG_ADDR);
  endfunction : hit

  always_comb begin
    field_next = field_reg;
    upper_next = upper_reg;
    rdata_next = fws_pkg::FWS_UNMAPPED_RD;
    if (reg_wr && hit(reg_addr)) begin // see [RULE7]
      field_next = reg_wdata[fws_pkg::FWS_FIELD_LSB +: fws_pkg::FWS_FIELD_W];
      // Upper bits stored as written; software keeps them as read, see [RULE6]
      upper_next = reg_wdata[31:2];
    end
    if (reg_rd && hit(reg_addr)) begin
      rdata_next = {upper_reg, field_reg};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      field_reg <= fws_pkg::FWS_FIELD_RESET; // see [RULE5]
      upper_reg <= fws_pkg::FWS_UPPER_RESET;
      rdata_reg <= fws_pkg::FWS_UNMAPPED_RD;
    end else begin
      field_reg <= field_next;
      upper_reg <= upper_next;
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Access stretching
  // --------------------------------------------------------------------------
  // Reserved code treated as slowest setting, keeps reads safe, see [RULE8]
  always_comb begin
    eff_wait = (field_reg == fws_pkg::FWS_FIELD_RSVD) ? fws_pkg::FWS_FIELD_MAXDEF
                                                      : field_reg; // see [RULE3] [RULE4]
  end

  fws_stretch u_stretch (
    .mclk        (mclk),
    .resetn      (resetn),
    .acc_req     (flash_req && !ack_reg),
    .wait_cycles (eff_wait),
    .acc_done    (done),
    .acc_busy    (busy)
  );

  // Ack registered: output rises the clock after the final access cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= done;
    end
  end

  assign reg_rdata          = rdata_reg;
  assign flash_ack          = ack_reg;
  assign access_cycle_field = field_reg;

  // --------------------------------------------------------------------------
  // Check helpers
  // --------------------------------------------------------------------------
  // Clocks of the access in flight, acceptance to acknowledge
  // Setting latched at acceptance: a write mid-access affects only the next
  logic [2:0]  acc_len_reg,  acc_len_next;
  logic [1:0]  acc_set_reg,  acc_set_next;
  logic        acc_open_reg, acc_open_next;

  // Spelled out per code, kept apart from the datapath arithmetic
  function automatic logic [2:0] exp_len(input logic [1:0] setting);
    case (setting)
      2'h0:    exp_len = 3'h1;
      2'h1:    exp_len = 3'h2;
      default: exp_len = 3'h3;
    endcase
  endfunction : exp_len

  always_comb begin
    acc_len_next  = acc_len_reg;
    acc_set_next  = acc_set_reg;
    acc_open_next = acc_open_reg;
    if (flash_ack) begin
      acc_open_next = 1'b0;
    end else if (acc_open_reg) begin
      // Saturates, a stuck access never wraps to a legal length
      if (acc_len_reg != 3'h7) begin
        acc_len_next = acc_len_reg + 3'h1;
      end
    end else if (flash_req && !busy) begin
      acc_open_next = 1'b1;
      acc_len_next  = 3'h1;
      acc_set_next  = field_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_len_reg  <= 3'h0;
      acc_set_reg  <= 2'h0;
      acc_open_reg <= 1'b0;
    end else begin
      acc_len_reg  <= acc_len_next;
      acc_set_reg  <= acc_set_next;
      acc_open_reg <= acc_open_next;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_cfg_read;
    reg_rd && hit(reg_addr);
  endsequence

  sequence s_ack_second;
    !flash_ack ##1 flash_ack;
  endsequence

  sequence s_ack_third;
    !flash_ack ##1 !flash_ack ##1 flash_ack;
  endsequence

  sequence s_busy_pair;
    busy ##1 busy;
  endsequence

  chk_read_returns_cfg: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE7]
    s_cfg_read |=> reg_rdata == {$past(upper_reg), $past(field_reg)})
    else $error("config read data wrong");

  chk_reset_field_val: assert property (@(posedge mclk) // see [RULE5]
    $rose(resetn) |-> field_reg == 2'h2)
    else $error("field not 10 after reset");

  chk_one_clk_access: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE2]
    (field_reg == 2'h0 && flash_req && !ack_reg && !busy) |=> flash_ack)
    else $error("one-clock access late");

  chk_two_clk_access: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE3]
    (field_reg == 2'h1 && flash_req && !ack_reg && !busy) |=> s_ack_second)
    else $error("two-clock access timing wrong");

  chk_rsvd_is_three: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE8]
    (field_reg == 2'h3 && flash_req && !ack_reg && !busy) |=> s_ack_third)
    else $error("reserved code not three clocks");

  chk_wr_updates_cfg: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE6]
    (reg_wr && hit(reg_addr)) |=> {upper_reg, field_reg} == $past(reg_wdata))
    else $error("config write not stored");

  chk_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE7]
    (reg_rd && !hit(reg_addr)) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  chk_ack_single: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    flash_ack |=> !flash_ack)
    else $error("ack longer than one cycle");

  chk_reset_outputs: assert property (@(posedge mclk) // see [RULE5]
    !resetn |=> !flash_ack && reg_rdata == fws_pkg::FWS_UNMAPPED_RD &&
      access_cycle_field == fws_pkg::FWS_FIELD_RESET)
    else $error("outputs not at reset values");

  chk_three_clk_access: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE4]
    (field_reg == 2'h2 && flash_req && !ack_reg && !busy) |=> s_ack_third)
    else $error("three-clock access timing wrong");

  chk_access_length: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    flash_ack |-> acc_open_reg && acc_len_reg == exp_len(acc_set_reg))
    else $error("access length differs from setting");

  chk_busy_bounded: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE4]
    s_busy_pair |=> !busy)
    else $error("access stretched beyond three clocks");

  chk_no_stray_ack: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    (!flash_req && !busy) |=> !flash_ack)
    else $error("ack without a request");

  chk_cfg_holds: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE5]
    !(reg_wr && hit(reg_addr)) |=> $stable({upper_reg, field_reg}))
    else $error("config changed without a write");

  chk_rdata_idle_zero: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE7]
    !reg_rd |=> reg_rdata == fws_pkg::FWS_UNMAPPED_RD)
    else $error("read data not cleared");

  chk_ack_when_idle: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    flash_ack |-> !busy)
    else $error("ack while access still stretched");

  chk_access_starts: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE1]
    (field_reg != 2'h0 && flash_req && !ack_reg && !busy) |=> busy)
    else $error("stretched access not started");

  chk_zero_no_wait: assert property (@(posedge mclk) disable iff (!resetn) // see [RULE2]
    (field_reg == 2'h0 && !busy) |=> !busy)
    else $error("one-clock setting entered wait");
endmodule : fws_top

// ---- verif/fws_flash_req.sv ----
// Flash requester model: raises a request and holds it until acknowledged.
// Assumes a one-cycle acknowledge pulse from the wait-state controller.
`timescale 1ns/10ps
module fws_flash_req (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic       ack,
  output logic            req,
  output logic            done,
  output logic      [3:0] lat
);
  logic [3:0] cnt;
  always @(posedge mclk) begin
    done <= 1'b0;
    if (!resetn) begin
      req <= 1'b0;
      cnt <= 4'h0;
    end else if (req) begin
      cnt <= cnt + 4'h1;
      if (ack) begin
        req  <= 1'b0;
        lat  <= cnt;
        done <= 1'b1;
      end
    end else if (go && !done) begin
      // Skip the done cycle after the ack so the bench can drop go first
      req <= 1'b1;
      cnt <= 4'h0;
    end
  end
endmodule : fws_flash_req

// ---- verif/flash_wait_state_control_bench.sv ----
// Bench: register bus tasks, flash requests with latency checks.
// Assumes fws_top and the requester model beside it.
`timescale 1ns/10ps
module flash_wait_state_control_bench;
  logic        mclk, resetn, reg_wr, reg_rd, go, req, ack, done;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, d, lfsr, ua;
  logic [1:0]  field, f;
  logic [3:0]  lat;
  int          err_count, samples_checked, cyc;
  fws_top uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_req(req), .flash_ack(ack), .access_cycle_field(field));
  fws_flash_req far (.mclk(mclk), .resetn(resetn), .go(go), .ack(ack), .req(req),
    .done(done), .lat(lat));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [3:0] exp_lat(input logic [1:0] x);
    return (x == 2'h3) ? 4'h3 : {2'h0, x} + 4'h1;
  endfunction : exp_lat
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : cmp
  // A missing completion counts as a mismatch, never a stale latency
  task automatic cmp_lat(input logic [3:0] e);
    samples_checked++;
    if (done !== 1'b1 || lat !== e) begin
      err_count++;
      $display("[ERR] latency exp %h got %h", e, (done === 1'b1) ? lat : 4'hf);
    end
  endtask : cmp_lat
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Held go gives back-to-back accesses
  task automatic acc(input int n, input logic [1:0] x);
    int i;
    @(posedge mclk);
    go <= 1'b1;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge mclk);
        i++;
      end while (done !== 1'b1 && i < 12);
      cmp_lat(exp_lat(x));
    end
    go <= 1'b0;
  endtask : acc
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, go, reg_addr, reg_wdata} = '0;
    {err_count, samples_checked, cyc} = '0;
    lfsr = 32'h3afbc2f2;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd(fws_pkg::FWS_CFG_ADDR);
    cmp("cfg", 32'h2, d);
    acc(1, 2'h2);
    for (int k = 0; k < 12; k++) begin
      lfsr = nxt(lfsr);
      f = (k < 4) ? k[1:0] : lfsr[1:0];
      ua = {lfsr[31:4], 4'h8};
      rd(fws_pkg::FWS_CFG_ADDR);
      wr(fws_pkg::FWS_CFG_ADDR, {d[31:2], f});
      wr(ua, ~lfsr);
      rd(ua);
      cmp("unmapped", 32'h0, d);
      rd(fws_pkg::FWS_CFG_ADDR);
      cmp("cfg", {30'h0, f}, d);
      cmp("field", {30'h0, f}, {30'h0, field});
      acc(2, f);
    end
    complete_run();
  end
endmodule : flash_wait_state_control_bench
